// ===== src/dz_ctrl_regs.sv
// door output control register bank with pwm timers and mode decode
//
// Summary of operation
// - frequency bit per pwm channel picks 100 Hz when clear, 200 Hz when set.
// - electrochrome sink switch on when its bit is set, off at reset.
// - electrochrome output overcurrent recovery enabled when set, off at reset.
// - electrochrome enable drives gate driver and forces output ten on.
// - six-bit electrochrome reference sets target as code/63 of full scale.
// - without high range, reference codes above 110011 clamp to 110011.
// - two-bit bridge monitor threshold picks one of four, reset is 11.
// - heater open-load diagnosis on when set, off at reset.
// - heater driver enabled when set, disabled at reset.
// - heater threshold 0000-1001 accepted; larger writes ignored, flag serial error.
// - slow decay side selects low or high switches; single-leg follows direction pin.
// - dual motor bridge mode when set, single motor at reset.
// - dead time codes 0010-1111 valid, reset 1111; 0000/0001 writes ignored, no error flag.
// - bridge open-load threshold 1/6 supply when clear, 5/6 when set.
// - two test bits each switch a pull-up on a bridge high terminal.
// - five-bit slew code sets code/31 of max, zero disables control.
// - output seven resistance variant, low when clear, high when set.
// - bits 17 to 8 enable overcurrent recovery per output, off at reset.
// - current monitor tristate when disabled; select routes chosen output.
// - monitor select codes 00000 and above 10000 deactivate the monitor.
// - four-bit mode selector decodes off, on, timers, pwm 1-10, directions.
// - pwm duty is code/1024 on-time, zero means off.
`timescale 1ns/10ps
`default_nettype none
module dz_ctrl_regs #(
  parameter int PWM_CHANNELS = dz_ctrl_pkg::PWM_CHANNELS,
  parameter int DUTY_W = dz_ctrl_pkg::DUTY_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  output logic reg_rvalid,
  output logic serial_error_flag,
  input wire logic electrochrome_high_range,
  input wire logic [PWM_CHANNELS*DUTY_W-1:0] pwm_duty,
  input wire logic timer_one,
  input wire logic timer_two,
  input wire logic direction_signal_one,
  input wire logic direction_signal_two,
  input wire logic bridge_direction_pin,
  input wire logic [3:0] output_ten_mode,
  output logic [PWM_CHANNELS-1:0] pwm_level,
  output logic high_side_output_ten,
  output logic [3:0] high_side_drive,
  output logic electrochrome_sink_switch,
  output logic electrochrome_recovery_enable,
  output logic electrochrome_gate_drive_pin,
  output logic [5:0] electrochrome_reference_code,
  output logic [1:0] bridge_monitor_threshold,
  output logic heater_openload_enable,
  output logic heater_driver_enable,
  output logic [3:0] heater_monitor_threshold,
  output logic slow_decay_side,
  output logic [1:0] slow_decay_leg_on,
  output logic dual_motor_select,
  output logic [3:0] crossconduction_dead_time,
  output logic bridge_openload_high_level,
  output logic openload_test_leg_a,
  output logic openload_test_leg_b,
  output logic [4:0] bridge_slew_code,
  output logic bridge_slew_active,
  output logic output7_resistance_select,
  output logic [9:0] output_recovery_enable,
  output logic current_monitor_enable,
  output logic [4:0] current_monitor_select
);
  if (PWM_CHANNELS != 10 || DUTY_W != 10) begin : g_param_check
    $error("mode decode serves exactly ten 10-bit pwm channels");
  end

  logic [23:0] pwm_rate_reg;
  logic [23:0] electrochrome_control;
  logic [23:0] bridge_heater_control;
  logic [23:0] recovery_monitor_control;
  logic [23:0] high_side_mode_select_a;
  logic [23:0] next_rdata;
  logic [23:0] bh_write;
  logic heat_th_bad;
  logic dead_time_bad;
  logic [5:0] ec_code_raw;
  logic [4:0] cm_sel_raw;
  logic [6:0] base_pre;
  logic [6:0] fast_pre;
  logic [DUTY_W-1:0] base_cnt;
  logic [DUTY_W-1:0] fast_cnt;

  localparam logic [6:0] BASE_STEP_LAST = 7'(dz_ctrl_pkg::PWM_BASE_STEP - 1);
  localparam logic [6:0] FAST_STEP_LAST = 7'(dz_ctrl_pkg::PWM_FAST_STEP - 1);

  // register writes: each register masks its reserved bits away
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwm_rate_reg <= dz_ctrl_pkg::PWM_RATE_RESET;
    end else if (reg_wr && reg_addr == dz_ctrl_pkg::PWM_RATE_ADDR) begin
      pwm_rate_reg <= reg_wdata & dz_ctrl_pkg::PWM_RATE_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      electrochrome_control <= dz_ctrl_pkg::EC_CTRL_RESET;
    end else if (reg_wr && reg_addr == dz_ctrl_pkg::EC_CTRL_ADDR) begin
      electrochrome_control <= reg_wdata & dz_ctrl_pkg::EC_CTRL_MASK;
    end
  end

  // invalid heater threshold or dead time codes keep the stored field
  assign heat_th_bad = reg_wdata[dz_ctrl_pkg::BH_HEAT_TH_LSB +: 4]
    > dz_ctrl_pkg::BH_HEAT_TH_MAX;
  assign dead_time_bad = reg_wdata[dz_ctrl_pkg::BH_DEAD_TIME_LSB +: 4]
    < dz_ctrl_pkg::BH_DEAD_TIME_MIN;

  always_comb begin
    bh_write = reg_wdata & dz_ctrl_pkg::BH_CTRL_MASK;
    if (heat_th_bad) begin
      bh_write[dz_ctrl_pkg::BH_HEAT_TH_LSB +: 4] =
        bridge_heater_control[dz_ctrl_pkg::BH_HEAT_TH_LSB +: 4];
    end
    if (dead_time_bad) begin
      // a forbidden dead time would risk shoot-through, so keep the old one
      bh_write[dz_ctrl_pkg::BH_DEAD_TIME_LSB +: 4] =
        bridge_heater_control[dz_ctrl_pkg::BH_DEAD_TIME_LSB +: 4];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bridge_heater_control <= dz_ctrl_pkg::BH_CTRL_RESET;
    end else if (reg_wr && reg_addr == dz_ctrl_pkg::BH_CTRL_ADDR) begin
      bridge_heater_control <= bh_write;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      serial_error_flag <= 1'b0;
    end else begin
      serial_error_flag <= reg_wr && reg_addr == dz_ctrl_pkg::BH_CTRL_ADDR
        && heat_th_bad;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      recovery_monitor_control <= dz_ctrl_pkg::RM_CTRL_RESET;
    end else if (reg_wr && reg_addr == dz_ctrl_pkg::RM_CTRL_ADDR) begin
      recovery_monitor_control <= reg_wdata & dz_ctrl_pkg::RM_CTRL_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      high_side_mode_select_a <= dz_ctrl_pkg::HSA_CTRL_RESET;
    end else if (reg_wr && reg_addr == dz_ctrl_pkg::HSA_CTRL_ADDR) begin
      high_side_mode_select_a <= reg_wdata & dz_ctrl_pkg::HSA_CTRL_MASK;
    end
  end

  // read path: unmapped addresses read zero
  always_comb begin
    unique case (reg_addr)
      dz_ctrl_pkg::PWM_RATE_ADDR: next_rdata = pwm_rate_reg;
      dz_ctrl_pkg::EC_CTRL_ADDR: next_rdata = electrochrome_control;
      dz_ctrl_pkg::BH_CTRL_ADDR: next_rdata = bridge_heater_control;
      dz_ctrl_pkg::RM_CTRL_ADDR: next_rdata = recovery_monitor_control;
      dz_ctrl_pkg::HSA_CTRL_ADDR: next_rdata = high_side_mode_select_a;
      default: next_rdata = 24'h000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 24'h000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // electrochrome controls
  assign ec_code_raw = electrochrome_control[dz_ctrl_pkg::EC_REF_LSB +: 6];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      electrochrome_sink_switch <= 1'b0;
      electrochrome_recovery_enable <= 1'b0;
      electrochrome_gate_drive_pin <= 1'b0;
      electrochrome_reference_code <= 6'h00;
    end else begin
      electrochrome_sink_switch <= electrochrome_control[dz_ctrl_pkg::EC_SINK_BIT];
      electrochrome_recovery_enable <=
        electrochrome_control[dz_ctrl_pkg::EC_RECOV_BIT];
      electrochrome_gate_drive_pin <= electrochrome_control[dz_ctrl_pkg::EC_ENABLE_BIT];
      // stored code stays readable as written; only the applied target clamps
      if (!electrochrome_high_range && ec_code_raw > dz_ctrl_pkg::EC_REF_LOW_RANGE_MAX) begin
        electrochrome_reference_code <= dz_ctrl_pkg::EC_REF_LOW_RANGE_MAX;
      end else begin
        electrochrome_reference_code <= ec_code_raw;
      end
    end
  end

  // bridge and heater controls
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bridge_monitor_threshold <= 2'h3;
      heater_openload_enable <= 1'b0;
      heater_driver_enable <= 1'b0;
      heater_monitor_threshold <= 4'h9;
      dual_motor_select <= 1'b0;
      crossconduction_dead_time <= 4'hF;
      bridge_openload_high_level <= 1'b0;
      openload_test_leg_a <= 1'b0;
      openload_test_leg_b <= 1'b0;
      bridge_slew_code <= 5'h00;
      bridge_slew_active <= 1'b0;
    end else begin
      bridge_monitor_threshold <= bridge_heater_control[dz_ctrl_pkg::BH_MON_TH_LSB +: 2];
      heater_openload_enable <= bridge_heater_control[dz_ctrl_pkg::BH_HEAT_OL_BIT];
      heater_driver_enable <= bridge_heater_control[dz_ctrl_pkg::BH_HEAT_EN_BIT];
      heater_monitor_threshold <= bridge_heater_control[dz_ctrl_pkg::BH_HEAT_TH_LSB +: 4];
      dual_motor_select <= bridge_heater_control[dz_ctrl_pkg::BH_DUAL_MOTOR_BIT];
      crossconduction_dead_time <=
        bridge_heater_control[dz_ctrl_pkg::BH_DEAD_TIME_LSB +: 4];
      bridge_openload_high_level <= bridge_heater_control[dz_ctrl_pkg::BH_OL_HIGH_BIT];
      openload_test_leg_a <= bridge_heater_control[dz_ctrl_pkg::BH_OL_LEG_A_BIT];
      openload_test_leg_b <= bridge_heater_control[dz_ctrl_pkg::BH_OL_LEG_B_BIT];
      bridge_slew_code <= bridge_heater_control[dz_ctrl_pkg::BH_SLEW_LSB +: 5];
      bridge_slew_active <= |bridge_heater_control[dz_ctrl_pkg::BH_SLEW_LSB +: 5];
    end
  end

  // slow decay: leg 0 is the one the direction pin names when low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slow_decay_side <= 1'b0;
      slow_decay_leg_on <= 2'h3;
    end else begin
      slow_decay_side <= bridge_heater_control[dz_ctrl_pkg::BH_DECAY_SIDE_BIT];
      if (bridge_heater_control[dz_ctrl_pkg::BH_DECAY_SINGLE_BIT]) begin
        slow_decay_leg_on <= bridge_direction_pin ? 2'h2 : 2'h1;
      end else begin
        slow_decay_leg_on <= 2'h3;
      end
    end
  end

  // recovery enables and current monitor
  assign cm_sel_raw = recovery_monitor_control[dz_ctrl_pkg::RM_CM_SEL_LSB +: 5];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      output7_resistance_select <= 1'b0;
      output_recovery_enable <= 10'h000;
      current_monitor_enable <= 1'b0;
      current_monitor_select <= 5'h00;
    end else begin
      output7_resistance_select <= recovery_monitor_control[dz_ctrl_pkg::RM_OUT7_RES_BIT];
      output_recovery_enable <= recovery_monitor_control[dz_ctrl_pkg::RM_RECOV_LSB +: 10];
      current_monitor_select <= cm_sel_raw;
      current_monitor_enable <= recovery_monitor_control[dz_ctrl_pkg::RM_CM_EN_BIT]
        && cm_sel_raw >= dz_ctrl_pkg::RM_CM_SEL_FIRST
        && cm_sel_raw <= dz_ctrl_pkg::RM_CM_SEL_LAST;
    end
  end

  // two shared pwm timebases; a channel picks one by its rate bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      base_pre <= 7'h00;
      base_cnt <= '0;
    end else if (base_pre == BASE_STEP_LAST) begin
      base_pre <= 7'h00;
      base_cnt <= base_cnt + 1'b1;
    end else begin
      base_pre <= base_pre + 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fast_pre <= 7'h00;
      fast_cnt <= '0;
    end else if (fast_pre == FAST_STEP_LAST) begin
      fast_pre <= 7'h00;
      fast_cnt <= fast_cnt + 1'b1;
    end else begin
      fast_pre <= fast_pre + 7'h01;
    end
  end

  // duty 1023 tops out one step short of full on, by design
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwm_level <= '0;
    end else begin
      for (int ch = 0; ch < PWM_CHANNELS; ch++) begin
        pwm_level[ch] <= (pwm_rate_reg[ch] ? fast_cnt : base_cnt)
          < pwm_duty[ch*DUTY_W +: DUTY_W];
      end
    end
  end

  dz_src_if src ();
  assign src.timer_one = timer_one;
  assign src.timer_two = timer_two;
  assign src.pwm_level = pwm_level;
  assign src.direction_signal_one = direction_signal_one;
  assign src.direction_signal_two = direction_signal_two;

  dz_hs_mode_dec u_out_ten (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .high_side_mode_field(output_ten_mode),
    .force_on(electrochrome_control[dz_ctrl_pkg::EC_ENABLE_BIT]),
    .src(src),
    .drive(high_side_output_ten)
  );

  // drive index 0..3 are outputs 13, 14, 15 and 0
  for (genvar k = 0; k < 4; k++) begin : g_hsa
    dz_hs_mode_dec u_dec (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .high_side_mode_field(high_side_mode_select_a[4*k +: 4]),
      .force_on(1'b0),
      .src(src),
      .drive(high_side_drive[k])
    );
  end
endmodule : dz_ctrl_regs
`default_nettype wire

// ===== src/dz_ctrl_pkg.sv
// constants for the door output control register bank
package dz_ctrl_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 24;
  localparam logic [6:0] PWM_RATE_ADDR = 7'h37;
  localparam logic [6:0] EC_CTRL_ADDR = 7'h38;
  localparam logic [6:0] BH_CTRL_ADDR = 7'h39;
  localparam logic [6:0] RM_CTRL_ADDR = 7'h3A;
  localparam logic [6:0] HSA_CTRL_ADDR = 7'h3B;
  // writable bits of each register; everything else reads zero
  localparam logic [23:0] PWM_RATE_MASK = 24'h0003FF;
  localparam logic [23:0] EC_CTRL_MASK = 24'h00313F;
  localparam logic [23:0] BH_CTRL_MASK = 24'h7FFFFF;
  localparam logic [23:0] RM_CTRL_MASK = 24'h83FF3F;
  localparam logic [23:0] HSA_CTRL_MASK = 24'h00FFFF;
  localparam logic [23:0] PWM_RATE_RESET = 24'h000000;
  localparam logic [23:0] EC_CTRL_RESET = 24'h000000;
  localparam logic [23:0] BH_CTRL_RESET = 24'h648F00;
  localparam logic [23:0] RM_CTRL_RESET = 24'h000020;
  localparam logic [23:0] HSA_CTRL_RESET = 24'h000000;
  // electrochrome register fields
  localparam int EC_SINK_BIT = 13;
  localparam int EC_RECOV_BIT = 12;
  localparam int EC_ENABLE_BIT = 8;
  localparam int EC_REF_LSB = 0;
  localparam logic [5:0] EC_REF_LOW_RANGE_MAX = 6'h33;
  // bridge / heater register fields
  localparam int BH_MON_TH_LSB = 21;
  localparam int BH_HEAT_OL_BIT = 20;
  localparam int BH_HEAT_EN_BIT = 19;
  localparam int BH_HEAT_TH_LSB = 15;
  localparam logic [3:0] BH_HEAT_TH_MAX = 4'h9;
  localparam int BH_DECAY_SIDE_BIT = 14;
  localparam int BH_DECAY_SINGLE_BIT = 13;
  localparam int BH_DUAL_MOTOR_BIT = 12;
  localparam int BH_DEAD_TIME_LSB = 8;
  localparam logic [3:0] BH_DEAD_TIME_MIN = 4'h2;
  localparam int BH_OL_HIGH_BIT = 7;
  localparam int BH_OL_LEG_A_BIT = 6;
  localparam int BH_OL_LEG_B_BIT = 5;
  localparam int BH_SLEW_LSB = 0;
  // recovery / monitor register fields
  localparam int RM_OUT7_RES_BIT = 23;
  localparam int RM_RECOV_LSB = 8;
  localparam int RM_CM_EN_BIT = 5;
  localparam int RM_CM_SEL_LSB = 0;
  localparam logic [4:0] RM_CM_SEL_FIRST = 5'h01;
  localparam logic [4:0] RM_CM_SEL_LAST = 5'h10;
  // high-side mode selector codes
  localparam logic [3:0] HS_MODE_OFF = 4'h0;
  localparam logic [3:0] HS_MODE_ON = 4'h1;
  localparam logic [3:0] HS_MODE_TIMER1 = 4'h2;
  localparam logic [3:0] HS_MODE_TIMER2 = 4'h3;
  localparam logic [3:0] HS_MODE_PWM_FIRST = 4'h4;
  localparam logic [3:0] HS_MODE_PWM_LAST = 4'hD;
  localparam logic [3:0] HS_MODE_DIRECTION_SIGNAL_ONE = 4'hE;
  localparam logic [3:0] HS_MODE_DIRECTION_SIGNAL_TWO = 4'hF;
  // pwm timing
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_BASE_HZ = 100;
  localparam int PWM_FAST_HZ = 200;
  localparam int PWM_STEPS = 1024;
  localparam int PWM_BASE_STEP = CLK_HZ / (PWM_BASE_HZ * PWM_STEPS);
  localparam int PWM_FAST_STEP = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
  localparam int PWM_CHANNELS = 10;
  localparam int DUTY_W = 10;
endpackage : dz_ctrl_pkg

// ===== src/dz_src_if.sv
// drive sources shared by the high-side mode decoders
`timescale 1ns/10ps
`default_nettype none
interface dz_src_if;
  logic timer_one;
  logic timer_two;
  logic [9:0] pwm_level;
  logic direction_signal_one;
  logic direction_signal_two;
  modport drv (output timer_one, output timer_two, output pwm_level,
    output direction_signal_one, output direction_signal_two);
  modport use_src (input timer_one, input timer_two, input pwm_level,
    input direction_signal_one, input direction_signal_two);
endinterface : dz_src_if
`default_nettype wire

// ===== src/dz_hs_mode_dec.sv
// four-bit high-side mode decoder with registered output
`timescale 1ns/10ps
`default_nettype none
module dz_hs_mode_dec (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] high_side_mode_field,
  input wire logic force_on,
  dz_src_if.use_src src,
  output logic drive
);
  logic next_drive;
  logic [3:0] pwm_idx;

  assign pwm_idx = high_side_mode_field - dz_ctrl_pkg::HS_MODE_PWM_FIRST;

  always_comb begin
    next_drive = 1'b0;
    if (force_on) begin
      next_drive = 1'b1;
    end else begin
      unique case (high_side_mode_field)
        dz_ctrl_pkg::HS_MODE_OFF: next_drive = 1'b0;
        dz_ctrl_pkg::HS_MODE_ON: next_drive = 1'b1;
        dz_ctrl_pkg::HS_MODE_TIMER1: next_drive = src.timer_one;
        dz_ctrl_pkg::HS_MODE_TIMER2: next_drive = src.timer_two;
        dz_ctrl_pkg::HS_MODE_DIRECTION_SIGNAL_ONE: next_drive = src.direction_signal_one;
        dz_ctrl_pkg::HS_MODE_DIRECTION_SIGNAL_TWO: next_drive = src.direction_signal_two;
        default: next_drive = src.pwm_level[pwm_idx];
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      drive <= 1'b0;
    end else begin
      drive <= next_drive;
    end
  end
endmodule : dz_hs_mode_dec
`default_nettype wire

// ===== bench/dz_ctrl_checker.sv
// assertion checker for the door output control registers
`timescale 1ns/10ps
`default_nettype none
module dz_ctrl_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic serial_error_flag,
  input wire logic electrochrome_high_range,
  input wire logic electrochrome_gate_drive_pin,
  input wire logic high_side_output_ten,
  input wire logic [5:0] electrochrome_reference_code,
  input wire logic [3:0] heater_monitor_threshold,
  input wire logic [3:0] crossconduction_dead_time,
  input wire logic [4:0] bridge_slew_code,
  input wire logic bridge_slew_active,
  input wire logic current_monitor_enable,
  input wire logic [4:0] current_monitor_select
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic bad_th;
  logic ec_on;
  assign bad_th = reg_wr && reg_addr == 7'h39 && reg_wdata[18:15] > 4'h9;
  assign ec_on = reg_wr && reg_addr == 7'h38 && reg_wdata[8];
  a_heater_error_pulse: assert property (bad_th |=> serial_error_flag)
    else $error("error flag missing");
  a_error_has_cause: assert property (serial_error_flag |-> $past(bad_th))
    else $error("error flag without cause");
  a_heater_th_range: assert property (heater_monitor_threshold <= 4'h9)
    else $error("heater threshold out of range");
  a_dead_time_range: assert property (crossconduction_dead_time >= 4'h2)
    else $error("dead time code not allowed");
  a_ec_clamp_limit: assert property (
    !$past(electrochrome_high_range) |-> electrochrome_reference_code <= 6'h33)
    else $error("reference not clamped");
  a_ec_enable_delay: assert property (
    ec_on |-> ##2 (electrochrome_gate_drive_pin && high_side_output_ten))
    else $error("gate driver or output ten late");
  a_gate_forces_ten: assert property (
    electrochrome_gate_drive_pin |-> high_side_output_ten)
    else $error("output ten not forced");
  a_slew_active_code: assert property (
    bridge_slew_active == (bridge_slew_code != 5'h00))
    else $error("slew active mismatch");
  a_monitor_valid_sel: assert property (
    current_monitor_enable |-> current_monitor_select inside {[5'h01:5'h10]})
    else $error("monitor on for empty select");
  c_bad_th: cover property (bad_th);
  c_ec_on: cover property (ec_on);
  c_cm_on: cover property (current_monitor_enable);
endmodule // dz_ctrl_checker
bind dz_ctrl_regs dz_ctrl_checker u_chk (.clk_sys, .rst_n, .reg_wr, .reg_addr,
  .reg_wdata, .serial_error_flag, .electrochrome_high_range,
  .electrochrome_gate_drive_pin, .high_side_output_ten, .electrochrome_reference_code,
  .heater_monitor_threshold, .crossconduction_dead_time, .bridge_slew_code,
  .bridge_slew_active, .current_monitor_enable, .current_monitor_select);
`default_nettype wire

// ===== bench/dz_host_model.sv
// host model driving the register port
`timescale 1ns/10ps
`default_nettype none
module dz_host_model (
  input wire logic clk_sys,
  input wire logic [23:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [23:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 24'h000000;
  end
  // released lines flip so a stale value never passes for a fresh one
  task automatic release_bus();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(negedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge clk_sys);
    release_bus();
  endtask
  task automatic rd(input logic [6:0] a, output logic [23:0] d);
    d = 24'hXXXXXX;
    @(negedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(negedge clk_sys);
    release_bus();
    for (int i = 0; i < 3; i++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(negedge clk_sys);
    end
  endtask
endmodule // dz_host_model
`default_nettype wire

// ===== bench/door_output_control_regs_test.sv
// self-checking bench for the door output control registers
`timescale 1ns/10ps
`default_nettype none
module door_output_control_regs_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic electrochrome_high_range = 1'b0;
  logic [99:0] pwm_duty = '0;
  logic timer_one = 1'b1;
  logic timer_two = 1'b0;
  logic direction_signal_one = 1'b1;
  logic direction_signal_two = 1'b1;
  logic bridge_direction_pin = 1'b0;
  logic [3:0] output_ten_mode = 4'h0;
  logic reg_wr, reg_rd, reg_rvalid, serial_error_flag, high_side_output_ten;
  logic electrochrome_sink_switch, electrochrome_recovery_enable;
  logic electrochrome_gate_drive_pin, heater_openload_enable, heater_driver_enable;
  logic slow_decay_side, dual_motor_select, bridge_openload_high_level;
  logic openload_test_leg_a, openload_test_leg_b, bridge_slew_active;
  logic output7_resistance_select, current_monitor_enable;
  logic [1:0] bridge_monitor_threshold, slow_decay_leg_on;
  logic [3:0] high_side_drive, heater_monitor_threshold, crossconduction_dead_time;
  logic [4:0] bridge_slew_code, current_monitor_select;
  logic [5:0] electrochrome_reference_code;
  logic [6:0] reg_addr;
  logic [9:0] pwm_level, output_recovery_enable;
  logic [23:0] reg_wdata, reg_rdata;
  int error_cnt = 0;
  int compares = 0;
  dz_ctrl_regs dut (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .serial_error_flag, .electrochrome_high_range, .pwm_duty,
    .timer_one, .timer_two, .direction_signal_one, .direction_signal_two,
    .bridge_direction_pin, .output_ten_mode, .pwm_level, .high_side_output_ten,
    .high_side_drive, .electrochrome_sink_switch, .electrochrome_recovery_enable,
    .electrochrome_gate_drive_pin, .electrochrome_reference_code,
    .bridge_monitor_threshold, .heater_openload_enable, .heater_driver_enable,
    .heater_monitor_threshold, .slow_decay_side, .slow_decay_leg_on, .dual_motor_select,
    .crossconduction_dead_time, .bridge_openload_high_level, .openload_test_leg_a,
    .openload_test_leg_b, .bridge_slew_code, .bridge_slew_active,
    .output7_resistance_select, .output_recovery_enable, .current_monitor_enable,
    .current_monitor_select);
  dz_host_model host (.clk_sys, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input string n, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic rchk(input string n, input logic [6:0] a, input logic [23:0] e);
    logic [23:0] d;
    host.rd(a, d);
    check(n, d, e);
  endtask
  task automatic t_reset();
    rchk("pwm_rate", 7'h37, 24'h000000);
    rchk("ec_ctrl", 7'h38, 24'h000000);
    rchk("bh_ctrl", 7'h39, 24'h648F00);
    rchk("rm_ctrl", 7'h3A, 24'h000020);
    rchk("hsa_ctrl", 7'h3B, 24'h000000);
    rchk("unmapped", 7'h00, 24'h000000);
    check("cm_en", current_monitor_enable, 1'b0);
    check("th_dead", {heater_monitor_threshold, crossconduction_dead_time}, 8'h9F);
    $display("test reset done");
  endtask
  task automatic t_reserved();
    logic [6:0] a[4] = '{7'h37, 7'h38, 7'h3A, 7'h3B};
    logic [23:0] m[4] = '{24'h0003FF, 24'h00313F, 24'h83FF3F, 24'h00FFFF};
    foreach (a[i]) begin
      host.wr(a[i], 24'hFFFFFF);
      rchk("masked", a[i], m[i]);
    end
    check("ec_out", {electrochrome_sink_switch, electrochrome_recovery_enable}, 2'h3);
    check("ec_ref", electrochrome_reference_code, 6'h33);
    check("ten", {electrochrome_gate_drive_pin, high_side_output_ten}, 2'h3);
    check("rm_out", {output7_resistance_select, output_recovery_enable}, 11'h7FF);
    check("cm_off", current_monitor_enable, 1'b0);
    check("hs_direction_signal_two", high_side_drive, 4'hF);
    $display("test reserved done");
  endtask
  task automatic t_ec();
    electrochrome_high_range <= 1'b1;
    tick(2);
    check("ec_full", electrochrome_reference_code, 6'h3F);
    host.wr(7'h38, 24'h000000);
    tick(1);
    check("ec_off", {electrochrome_gate_drive_pin, high_side_output_ten}, 2'h0);
    output_ten_mode <= 4'h1;
    tick(3);
    check("ten_mode", high_side_output_ten, 1'b1);
    output_ten_mode <= 4'h0;
    $display("test ec done");
  endtask
  task automatic t_heater();
    host.wr(7'h39, 24'h3D72D5);
    check("err_flag", serial_error_flag, 1'b1);
    rchk("bh_bad", 7'h39, 24'h3CF2D5);
    check("bh_fields", {bridge_monitor_threshold, heater_openload_enable,
      heater_driver_enable, slow_decay_side, dual_motor_select,
      bridge_openload_high_level, openload_test_leg_a, openload_test_leg_b,
      bridge_slew_code, bridge_slew_active}, 16'h3FAB);
    check("leg_low", slow_decay_leg_on, 2'h1);
    bridge_direction_pin <= 1'b1;
    tick(2);
    check("leg_high", slow_decay_leg_on, 2'h2);
    host.wr(7'h39, 24'h000200);
    check("no_err", serial_error_flag, 1'b0);
    rchk("bh_low", 7'h39, 24'h000200);
    check("leg_both", slow_decay_leg_on, 2'h3);
    host.wr(7'h39, 24'h000F00);
    rchk("dead_max", 7'h39, 24'h000F00);
    $display("test heater done");
  endtask
  task automatic t_monitor();
    logic [23:0] d[5] = '{24'h000021, 24'h000030, 24'h000031, 24'h000020, 24'h000001};
    logic e[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    foreach (d[i]) begin
      host.wr(7'h3A, d[i]);
      tick(2);
      check("cm_sel", current_monitor_enable, e[i]);
    end
    $display("test monitor done");
  endtask
  task automatic t_modes();
    logic [3:0] c;
    direction_signal_two <= 1'b0;
    // duty zero keeps every pwm channel off
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      host.wr(7'h3B, {8'h00, c, c, c, c});
      tick(3);
      check("hs_mode", high_side_drive, (c == 4'h1 || c == 4'h2 || c == 4'hE) ? 4'hF : 4'h0);
    end
    $display("test modes done");
  endtask
  task automatic t_pwm();
    rst_n <= 1'b0;
    pwm_duty[19:0] <= 20'h00802;
    tick(4);
    rst_n <= 1'b1;
    host.wr(7'h37, 24'h000002);
    tick(147);
    check("pwm_rate", pwm_level[1:0], 2'h1);
    $display("test pwm done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_reserved();
    t_ec();
    t_heater();
    t_monitor();
    t_modes();
    t_pwm();
    stop_test();
  end
endmodule // door_output_control_regs_test
`default_nettype wire
